// ==== src/scl_loader.sv ====
`timescale 1ns/1ps
module scl_loader (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CFG_CLK_IN,
  input  wire logic        CFG_DATA,
  input  wire logic        RESET_N_PIN,
  input  wire logic        INIT_N_IN,
  output logic             INIT_N_OUT,
  output logic             INIT_N_OE,
  output logic             CFG_CLK_OUT,
  output logic             CFG_CLK_OE,
  output logic             CHAIN_OUT,
  output logic             DONE,
  output logic             IO_ACTIVE,
  output logic             GLOBAL_RESET,
  output logic [15:0]      FRAME_DATA,
  output logic [7:0]       FRAME_ADDR,
  output logic             FRAME_WE,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] clk_s, dat_s, rst_s, init_s;
  logic       clk_d;
  // Two stages each; only the second is read
  always_ff @(posedge CLK) begin
    clk_s <= {clk_s[0], CFG_CLK_IN};
    dat_s <= {dat_s[0], CFG_DATA};
    rst_s <= {rst_s[0], RESET_N_PIN};
    init_s <= {init_s[0], INIT_N_IN};
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      clk_d <= 1'b1; // Pin idles high: no false rise after reset
    end else begin
      clk_d <= clk_s[1];
    end
  end
  logic rise, fall, enabled;
  logic [4:0] ctrl;
  logic       ser_clk, ser_rise, ser_fall, ser_bit;
  // Byte mode uses the internal serialiser clock instead of the pin
  assign rise    = ctrl[scl_pkg::CTRL_BYTE_MODE] ? ser_rise : (clk_s[1] & ~clk_d);
  assign fall    = ctrl[scl_pkg::CTRL_BYTE_MODE] ? ser_fall : (~clk_s[1] & clk_d);
  assign enabled = rst_s[1] & init_s[1] & ~INIT_N_OE;
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       ph_wr, ph_rd;
  logic [7:0] ph_addr;
  logic [7:0] byte_buf;
  logic       byte_full;
  logic       byte_take;
  // Address phase captured; zero wait states
  always_ff @(posedge CLK) begin
    if (RST) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr   <= HSEL & HREADY & HTRANS[1] & HWRITE;
      ph_rd   <= HSEL & HREADY & HTRANS[1] & ~HWRITE;
      ph_addr <= HADDR[7:0];
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  // Control bits steer options and mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= scl_pkg::CTRL_RESET;
    end else if (ph_wr && ph_addr == scl_pkg::ADDR_CTRL) begin
      ctrl <= HWDATA[4:0];
    end
  end
  // Byte host load; a new write while full is dropped
  always_ff @(posedge CLK) begin
    if (RST) begin
      byte_buf  <= 8'h00;
      byte_full <= 1'b0;
    end else if (ph_wr && ph_addr == scl_pkg::ADDR_BYTE && !byte_full) begin
      byte_buf  <= HWDATA[7:0];
      byte_full <= 1'b1;
    end else if (byte_take) begin
      byte_full <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Parallel to serial converter
  // ----------------------------------------------------------------
  logic [7:0] ser_sr;
  logic [3:0] ser_cnt;
  assign byte_take = byte_full && ser_cnt == 4'h0 && !ser_clk;
  assign ser_bit   = ser_sr[7];
  assign ser_rise  = ~ser_clk & (ser_cnt != 4'h0);
  assign ser_fall  = ser_clk;
  // Internally made clock: one bit per two system cycles, MSB first
  always_ff @(posedge CLK) begin
    if (RST) begin
      ser_sr  <= 8'hFF;
      ser_cnt <= 4'h0;
      ser_clk <= 1'b0;
    end else if (byte_take) begin
      ser_sr  <= byte_buf;
      ser_cnt <= 4'h8;
    end else if (ser_cnt != 4'h0) begin
      ser_clk <= ~ser_clk;
      if (ser_clk) begin
        ser_sr  <= {ser_sr[6:0], 1'b1};
        ser_cnt <= ser_cnt - 4'h1;
      end
    end
  end
  // Device drives its clock pin only in byte mode
  assign CFG_CLK_OUT = ser_clk;
  assign CFG_CLK_OE  = ctrl[scl_pkg::CTRL_BYTE_MODE];
  // ----------------------------------------------------------------
  // Header and frame engine
  // ----------------------------------------------------------------
  logic                                 din;
  assign din = ctrl[scl_pkg::CTRL_BYTE_MODE] ? ser_bit : dat_s[1];
  scl_pkg::scl_state_t                  state;
  logic [3:0]                           hdr_sr;
  logic [2:0]                           ones;
  logic [4:0]                           len_cnt;
  logic [scl_pkg::LEN_BITS-1:0]         length, counter;
  logic [scl_pkg::FRAME_BITS+3:0]       frame_sr;
  logic [scl_pkg::PTR_BITS-1:0]         frames_left, ptr;
  logic                                 fout, last_xfer;
  logic                                 match;
  assign match = (counter == length) && state != scl_pkg::SCL_HUNT;
  assign last_xfer = state == scl_pkg::SCL_FRAMES && !frame_sr[scl_pkg::FRAME_BITS+3] &&
                     frames_left == 8'h01;
  // Counts every enabled rising edge, preamble included
  always_ff @(posedge CLK) begin
    if (RST || !enabled) begin
      counter <= '0;
    end else if (rise) begin
      counter <= counter + 24'h00_0001;
    end
  end
  // Frame count comes from the length low bits for this model
  always_ff @(posedge CLK) begin
    if (RST || !enabled) begin
      state    <= scl_pkg::SCL_HUNT;
      hdr_sr   <= 4'hF;
      ones     <= 3'h0;
      len_cnt  <= 5'h00;
      length   <= '1;
      frame_sr <= '1;
      ptr      <= '0;
      frames_left <= '0;
      FRAME_WE <= 1'b0;
      FRAME_DATA <= 16'h0000;
      FRAME_ADDR <= 8'h00;
    end else begin
      FRAME_WE <= 1'b0;
      if (rise) begin
        case (state)
          scl_pkg::SCL_HUNT: begin
            hdr_sr <= {hdr_sr[2:0], din};
            if (din && ones != 3'(scl_pkg::LEAD_ONES)) begin
              ones <= ones + 3'h1;
            end
            if ({hdr_sr[2:0], din} == scl_pkg::SYNC_PATTERN &&
                ones == 3'(scl_pkg::LEAD_ONES)) begin
              state   <= scl_pkg::SCL_LEN;
              len_cnt <= 5'h00;
            end
          end
          scl_pkg::SCL_LEN: begin
            length  <= {length[scl_pkg::LEN_BITS-2:0], din};
            len_cnt <= len_cnt + 5'h01;
            if (len_cnt == 5'(scl_pkg::LEN_BITS - 1)) begin
              state   <= scl_pkg::SCL_TAIL;
              len_cnt <= 5'h00;
            end
          end
          scl_pkg::SCL_TAIL: begin
            len_cnt <= len_cnt + 5'h01;
            if (len_cnt == 5'h03) begin
              state       <= scl_pkg::SCL_FRAMES;
              frames_left <= length[scl_pkg::PTR_BITS-1:0];
            end
          end
          scl_pkg::SCL_FRAMES: begin
            if (frame_sr[scl_pkg::FRAME_BITS+3] == 1'b0) begin
              // Start bit at far end: transfer and restart shifting
              FRAME_DATA <= frame_sr[scl_pkg::FRAME_BITS+2:3];
              FRAME_WE   <= 1'b1;
              FRAME_ADDR <= ptr;
              ptr        <= ptr + 8'h01;
              frame_sr   <= {{(scl_pkg::FRAME_BITS+3){1'b1}}, din};
              if (ctrl[scl_pkg::CTRL_STOP_CHK] && !ctrl[scl_pkg::CTRL_CRC_EN] &&
                  frame_sr[2:0] != scl_pkg::STOP_OK) begin
                state <= scl_pkg::SCL_ERROR;
              end else if (frames_left == 8'h01) begin
                state <= scl_pkg::SCL_PASS;
              end
              frames_left <= frames_left - 8'h01;
            end else begin
              frame_sr <= {frame_sr[scl_pkg::FRAME_BITS+2:0], din};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // Chain output: header echoed, then high, then pass after load
  always_ff @(posedge CLK) begin
    if (RST || !enabled) begin
      fout      <= 1'b1;
      CHAIN_OUT <= 1'b1;
    end else begin
      if (rise) begin
        fout <= (state == scl_pkg::SCL_HUNT || state == scl_pkg::SCL_LEN ||
                 state == scl_pkg::SCL_PASS || last_xfer) ? din : 1'b1;
      end
      if (fall) begin
        CHAIN_OUT <= fout;
      end
    end
  end
  // Init pin pulled low after a failed frame check
  always_ff @(posedge CLK) begin
    if (RST) begin
      INIT_N_OE <= 1'b0;
    end else if (!rst_s[1]) begin
      INIT_N_OE <= 1'b0;
    end else if (state == scl_pkg::SCL_ERROR) begin
      INIT_N_OE <= 1'b1;
    end
  end
  assign INIT_N_OUT = 1'b0;
  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  logic [2:0] su_cnt, su_step;
  logic       su_run, su_go;
  // Steps counted in rising edges from match; I/O at step 1
  always_ff @(posedge CLK) begin
    if (RST || !enabled) begin
      su_run <= 1'b0;
      su_cnt <= 3'h0;
    end else if (rise) begin
      if (match && state == scl_pkg::SCL_PASS && !su_run) begin
        su_run <= 1'b1;
        su_cnt <= 3'h1;
      end else if (su_run && su_cnt != 3'h7) begin
        su_cnt <= su_cnt + 3'h1;
      end
    end
  end
  // Match edge itself is step 0, so early events need no extra edge
  assign su_go   = su_run | (match & (state == scl_pkg::SCL_PASS));
  assign su_step = su_run ? su_cnt : 3'h0;
  // All changes land on one rising edge each, shared by the chain
  always_ff @(posedge CLK) begin
    if (RST || !enabled) begin
      IO_ACTIVE    <= 1'b0;
      DONE         <= 1'b0;
      GLOBAL_RESET <= 1'b1;
    end else if (rise && su_go) begin
      if (su_step == 3'(scl_pkg::IO_DELAY - 1)) begin
        IO_ACTIVE <= 1'b1;
      end
      if (su_step == (ctrl[scl_pkg::CTRL_LATE_DONE] ? 3'(scl_pkg::IO_DELAY) :
                     3'(scl_pkg::IO_DELAY - 2))) begin
        DONE <= 1'b1;
      end
      if (su_step == (ctrl[scl_pkg::CTRL_EARLY_REL] ? 3'(scl_pkg::IO_DELAY - 2) :
                     3'(scl_pkg::IO_DELAY))) begin
        GLOBAL_RESET <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
    end else if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      if (HADDR[7:0] == scl_pkg::ADDR_CTRL) begin
        HRDATA <= {27'h000_0000, ctrl};
      end else if (HADDR[7:0] == scl_pkg::ADDR_STATUS) begin
        HRDATA <= {24'h00_0000, byte_full, INIT_N_OE, GLOBAL_RESET, IO_ACTIVE,
                   DONE, state};
      end else if (HADDR[7:0] == scl_pkg::ADDR_LENGTH) begin
        HRDATA <= {8'h00, length};
      end else if (HADDR[7:0] == scl_pkg::ADDR_COUNT) begin
        HRDATA <= {8'h00, counter};
      end else if (HADDR[7:0] == scl_pkg::ADDR_FRAMES) begin
        HRDATA <= {24'h00_0000, ptr};
      end else begin
        HRDATA <= 32'h0000_0000;
      end
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property io_after_match_p;
    @(posedge CLK) disable iff (RST)
      $rose(IO_ACTIVE) |-> su_run;
  endproperty
  io_after_match_a: assert property (io_after_match_p) else $error("io without start-up");
  default_order_a: assert property (@(posedge CLK) disable iff (RST)
      ($rose(IO_ACTIVE) && ctrl == 5'h00) |-> DONE && GLOBAL_RESET)
    else $error("default order broken");
  held_reset_a: assert property (@(posedge CLK) disable iff (RST)
      !IO_ACTIVE && !su_run |-> GLOBAL_RESET) else $error("reset not held");
  count_step_a: assert property (@(posedge CLK) disable iff (RST)
      (rise && enabled) |=> counter == $past(counter) + 24'h00_0001 || counter == 24'h00_0000)
    else $error("counter missed edge");
  clear_a: assert property (@(posedge CLK) disable iff (RST)
      !enabled |=> counter == 24'h00_0000 && state == scl_pkg::SCL_HUNT)
    else $error("not cleared");
  chain_fall_a: assert property (@(posedge CLK) disable iff (RST)
      (CHAIN_OUT != $past(CHAIN_OUT)) |-> $past(fall) || !$past(enabled))
    else $error("chain changed off edge");
  chain_high_a: assert property (@(posedge CLK) disable iff (RST)
      (state == scl_pkg::SCL_FRAMES) [*3] |-> CHAIN_OUT) else $error("chain not high");
  init_fail_a: assert property (@(posedge CLK) disable iff (RST)
      state == scl_pkg::SCL_ERROR && rst_s[1] |=> INIT_N_OE) else $error("init not low");
  frame_we_a: assert property (@(posedge CLK) disable iff (RST)
      FRAME_WE |-> ptr == FRAME_ADDR + 8'h01) else $error("pointer not advanced");
  startup_edge_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(IO_ACTIVE) |-> $past(rise)) else $error("start-up off clock edge");
endmodule

// ==== src/scl_pkg.sv ====
package scl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_LENGTH = 8'h08;
  localparam logic [7:0]  ADDR_COUNT  = 8'h0C;
  localparam logic [7:0]  ADDR_FRAMES = 8'h10;
  localparam logic [7:0]  ADDR_BYTE   = 8'h14;
  localparam int          CTRL_LATE_DONE  = 0;
  localparam int          CTRL_EARLY_REL  = 1;
  localparam int          CTRL_CRC_EN     = 2;
  localparam int          CTRL_STOP_CHK   = 3;
  localparam int          CTRL_BYTE_MODE  = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h00;
  // ----------------------------------------------------------------
  // Bitstream format
  // ----------------------------------------------------------------
  localparam logic [3:0]  SYNC_PATTERN = 4'h2;
  localparam int          LEN_BITS     = 24;
  localparam int          FRAME_BITS   = 16;
  localparam int          PTR_BITS     = 8;
  localparam int          LEAD_ONES    = 4;
  localparam logic [2:0]  STOP_OK      = 3'h7;
  localparam int          IO_DELAY     = 2;
  typedef enum logic [2:0] {
    SCL_HUNT   = 3'b000,
    SCL_LEN    = 3'b001,
    SCL_TAIL   = 3'b010,
    SCL_FRAMES = 3'b011,
    SCL_PASS   = 3'b100,
    SCL_ERROR  = 3'b101
  } scl_state_t;
endpackage

// ==== verif/scl_src_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial configuration source
// ----------------------------------------------------------------
module scl_src_model (
  output logic cfg_clk,
  output logic cfg_data
);
  // Idle high: only the low phase has a bound, so park there
  initial begin
    cfg_clk  = 1'h1;
    cfg_data = 1'h1;
  end
  // Source drives the clock; data moves on the falling edge
  task automatic play(input logic s[$], input int n);
    #1.3;
    for (int i = 0; i < n; i++) begin
      cfg_clk  = 1'h0;
      cfg_data = s[i];
      #62.5;
      cfg_clk  = 1'h1;
      #62.5;
    end
    // Released line must not keep showing the last bit
    cfg_data = ~cfg_data;
  endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  localparam logic [23:0] LEN  = 24'h00_0102;
  localparam int          HDR  = 40;
  localparam int          FEND = 80;
  logic        clk = 1'h0, rst = 1'h1, rstn = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic        cfg_clk, cfg_data, init_oe, init_o, chain, done, io_act, grst, fwe;
  logic        hready, hresp, clk_oe, clk_out;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h2;
  logic [7:0]  faddr, bv;
  logic [15:0] fdata;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic        sent[$];
  logic [15:0] fexp[2] = '{16'hA5A5, 16'h8181};
  int          miscompares = 0, n_compared = 0, cyc = 0;
  int          rise_n, done_at, io_at, rel_at, fidx, ser_n;
  bit          mon_en = 1'b0, fmon_en = 1'b0;
  // Open-drain init pin with pull-up
  wire         init_n = init_oe ? init_o : 1'h1;

  scl_loader scl_loader_i (
    .CLK(clk), .RST(rst), .CFG_CLK_IN(cfg_clk), .CFG_DATA(cfg_data),
    .RESET_N_PIN(rstn), .INIT_N_IN(init_n), .INIT_N_OUT(init_o), .INIT_N_OE(init_oe),
    .CFG_CLK_OUT(clk_out), .CFG_CLK_OE(clk_oe), .CHAIN_OUT(chain), .DONE(done),
    .IO_ACTIVE(io_act),
    .GLOBAL_RESET(grst), .FRAME_DATA(fdata), .FRAME_ADDR(faddr), .FRAME_WE(fwe),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
  scl_src_model scl_src_model_i (.cfg_clk(cfg_clk), .cfg_data(cfg_data));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic fail(string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_bit(logic g, logic e, string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_word(logic [31:0] g, logic [31:0] e, string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_num(int g, int e, string m);
    n_compared++;
    if (g != e) fail(m);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Single word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    r = hrdata;
    chk_bit(hresp, 1'h0, "response not okay");
  endtask
  task automatic do_reset();
    rst <= 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
  endtask
  // Header, frames with 3 stop bits, then filler to pass through
  task automatic build(input bit bad, input int total);
    sent.delete();
    for (int i = 0; i < 8; i++) sent.push_back(1'h1);
    for (int i = 3; i >= 0; i--) sent.push_back(scl_pkg::SYNC_PATTERN[i]);
    for (int i = 23; i >= 0; i--) sent.push_back(LEN[i]);
    for (int i = 0; i < 4; i++) sent.push_back(1'h1);
    for (int f = 0; f < 2; f++) begin
      sent.push_back(1'h0);
      for (int i = 15; i >= 0; i--) sent.push_back(fexp[f][i]);
      for (int i = 0; i < 3; i++) sent.push_back(!(bad && i == 2));
    end
    while (sent.size() < total) sent.push_back(sent.size() % 3 == 0);
  endtask
  // Header echoed, high while own frames load, then pass-through
  function automatic logic exp_chain(int r);
    return (r > HDR && r <= FEND) ? 1'h1 : sent[r - 1];
  endfunction

  // ----------------------------------------------------------------
  // Monitors and stimulus
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // Hang guard, well above three full loads
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      report_and_stop();
    end
  end
  // Outputs sampled just before each link rise see the previous step
  always @(posedge cfg_clk) begin
    if (mon_en) begin
      rise_n++;
      if (rise_n > 1) chk_bit(chain, exp_chain(rise_n - 1), "chain out");
      if (rise_n <= int'(LEN)) chk_bit(done | io_act | ~grst, 1'h0, "early start");
      if (done === 1'h1 && done_at == 0) done_at = rise_n;
      if (io_act === 1'h1 && io_at == 0) io_at = rise_n;
      if (grst === 1'h0 && rel_at == 0) rel_at = rise_n;
    end
  end
  // Frame writes land in order at consecutive addresses
  always @(posedge clk) begin
    if (fmon_en && fwe === 1'h1) begin
      chk_word({16'h0000, fdata}, {16'h0000, fexp[fidx % 2]}, "frame data");
      chk_word({24'h00_0000, faddr}, fidx, "frame address");
      fidx++;
    end
  end
  // Serialiser clock pulses driven out on the clock pin
  always @(posedge clk_out) ser_n++;
  task automatic run(input logic [31:0] ctrl, input int d_rel, input int r_rel,
                     input bit abort, input string name);
    logic [31:0] r;
    do_reset();
    ahb(1'h1, scl_pkg::ADDR_CTRL, ctrl, r);
    ahb(1'h0, scl_pkg::ADDR_CTRL, 32'h0000_0000, r);
    chk_word(r, ctrl, "control readback");
    chk_bit(clk_oe, 1'h0, "clock driven in pin mode");
    build(1'b0, int'(LEN) + 6);
    if (abort) begin
      scl_src_model_i.play(sent, 20);
      @(posedge clk);
      rstn <= 1'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'h1;
      repeat (5) @(posedge clk);
    end
    chk_bit(grst, 1'h1, "reset not held");
    {rise_n, done_at, io_at, rel_at, fidx} = '0;
    {mon_en, fmon_en} = 2'b11;
    scl_src_model_i.play(sent, sent.size());
    {mon_en, fmon_en} = 2'b00;
    chk_num(fidx, 2, "frame count");
    chk_num(done_at - io_at, d_rel, "done order");
    chk_num(rel_at - io_at, r_rel, "release order");
    chk_bit(io_at > int'(LEN) && io_at <= int'(LEN) + 3, 1'h1, "io time");
    chk_bit(init_oe, 1'h0, "init pulled");
    ahb(1'h0, scl_pkg::ADDR_LENGTH, 32'h0000_0000, r);
    chk_word(r, {8'h00, LEN}, "stored length");
    $display("test %s done", name);
  endtask
  initial begin
    do_reset();
    ahb(1'h0, scl_pkg::ADDR_CTRL, 32'h0000_0000, rd);
    chk_word(rd, 32'h0000_0000, "control reset value");
    ahb(1'h0, 8'h20, 32'h0000_0000, rd);
    chk_word(rd, 32'h0000_0000, "unmapped read");
    $display("test registers done");
    run(32'h0000_0000, -1, 1, 1'b0, "default start-up");
    run(32'h0000_0003, 1, -1, 1'b1, "options after abort");
    // Byte host: header and two frames through the serialiser
    do_reset();
    ahb(1'h1, scl_pkg::ADDR_CTRL, 32'h0000_0010, rd);
    build(1'b0, 88);
    {ser_n, fidx} = '0;
    fmon_en = 1'b1;
    for (int b = 0; b < 11; b++) begin
      for (int i = 0; i < 8; i++) bv[7 - i] = sent[8 * b + i];
      do ahb(1'h0, scl_pkg::ADDR_STATUS, 32'h0000_0000, rd); while (rd[7] === 1'h1);
      ahb(1'h1, scl_pkg::ADDR_BYTE, {24'h00_0000, bv}, rd);
    end
    repeat (40) @(posedge clk);
    fmon_en = 1'b0;
    chk_bit(clk_oe, 1'h1, "clock not driven in byte mode");
    chk_num(fidx, 2, "byte mode frames");
    chk_num(ser_n, 88, "serial clock pulses");
    $display("test byte mode done");
    // Broken stop bit in the first frame must stop the load
    do_reset();
    ahb(1'h1, scl_pkg::ADDR_CTRL, 32'h0000_0008, rd);
    build(1'b1, 70);
    scl_src_model_i.play(sent, sent.size());
    repeat (4) @(posedge clk);
    chk_bit(init_oe, 1'h1, "stop check");
    chk_bit(io_act, 1'h0, "io after error");
    $display("test stop check done");
    report_and_stop();
  end
endmodule
